/* include/split_intr_cfg.svh */
// Offsets, descriptor field positions, reset values and timing counts.
// Assumes a 10 MHz clock and byte addresses on a 32-bit AHB-Lite bus.
`ifndef SPLIT_INTR_CFG_SVH
`define SPLIT_INTR_CFG_SVH

// ==========================================
// Register offsets
`define OFS_DESC_LO 8'h00
`define OFS_DESC_HI 8'h04
`define OFS_POLL 8'h08
`define OFS_ACTIVE 8'h0c
`define OFS_STATUS 8'h10
`define OFS_PROGRESS 8'h14

// ==========================================
// Descriptor field positions, counted over the 64-bit pair {hi, lo}; the last two over the poll register
`define SPLIT_BIT 46
`define KIND_HI 45
`define KIND_LO 44
`define TOKEN_HI 43
`define TOKEN_LO 42
`define FADDR_HI 41
`define FADDR_LO 35
`define EP_HI 34
`define EP_LO 32
`define EP_BIT0 31
`define MPS_HI 28
`define MPS_LO 18
`define BCNT_HI 17
`define BCNT_LO 3
`define VALID_BIT 0
`define POLL_HI 7
`define POLL_LO 3

// ==========================================
// Encodings and reset values
`define KIND_INTR 2'h3
`define TOKEN_OUT 2'h0
`define TOKEN_IN 2'h1
`define RST_WORD 32'h0000_0000

// ==========================================
// Timing
`define CLK_NS 100
`define UFRAME_NS 125000
`define UFRAME_CYCLES (`UFRAME_NS / `CLK_NS)
`define UFRAMES_PER_MS 8

`endif

/* include/split_intr_pkg.sv */
// Types shared by the split interrupt descriptor block.
// Assumes nothing beyond a SystemVerilog compiler.
package split_intr_pkg;

    // ==========================================
    // Execution states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_BUSY = 3'b100
    } exec_state_t;

    typedef logic [31:0] word_t;
    typedef logic [14:0] byte_count_t;
    typedef logic [10:0] payload_t;

endpackage

/* hdl/descriptor_fields.sv */
// Pulls the fields out of the lower descriptor doublewords.
// Assumes the caller holds the words in registers; purely combinational.
`timescale 1ns/1ns
`default_nettype none
`include "split_intr_cfg.svh"

module descriptor_fields
    import split_intr_pkg::*;
(
    input wire logic [31:0] desc_lo,
    input wire logic [31:0] desc_hi,
    input wire logic [7:0] uframe,
    output logic split_sel,
    output logic [1:0] transfer_kind,
    output logic token_in,
    output logic legal,
    output logic [6:0] function_addr,
    output logic [3:0] endpoint_number,
    output payload_t max_payload_size,
    output byte_count_t transfer_byte_count,
    output logic desc_valid,
    output logic [2:0] poll_exp
);

    // ==========================================
    // Polling code to period exponent in milliseconds
    function automatic logic [2:0] poll_exp_of(input logic [4:0] code);
        logic [2:0] e;
        e = 3'h0;
        for (int i = 0; i < 5; i++) begin
            if (code[i]) begin
                e = 3'(i + 1);
            end
        end
        return e;
    endfunction

    wire logic [63:0] desc = {desc_hi, desc_lo};
    wire logic [1:0] token = desc[`TOKEN_HI:`TOKEN_LO];

    assign split_sel = desc[`SPLIT_BIT]; // see R1
    assign transfer_kind = desc[`KIND_HI:`KIND_LO]; // see R2
    assign token_in = (token == `TOKEN_IN); // see R2
    assign legal = (transfer_kind == `KIND_INTR) &&
                   ((token == `TOKEN_IN) || (token == `TOKEN_OUT)); // see R2
    assign function_addr = desc[`FADDR_HI:`FADDR_LO]; // see R3
    assign endpoint_number = {desc[`EP_HI:`EP_LO], desc[`EP_BIT0]}; // see R4
    assign max_payload_size = desc[`MPS_HI:`MPS_LO]; // see R5
    assign transfer_byte_count = desc[`BCNT_HI:`BCNT_LO]; // see R7
    assign desc_valid = desc[`VALID_BIT]; // see R10
    assign poll_exp = poll_exp_of(uframe[`POLL_HI:`POLL_LO]); // see R11 see R13

endmodule
`default_nettype wire

/* hdl/poll_timer.sv */
// Counts microframes and pulses once per polling period.
// Assumes a 10 MHz clock; restart holds the count at zero.
`timescale 1ns/1ns
`default_nettype none
`include "split_intr_cfg.svh"

module poll_timer
    import split_intr_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic restart,
    input wire logic [2:0] poll_exp,
    output logic due
);

    localparam logic [10:0] TICK_LAST = 11'(`UFRAME_CYCLES - 1);

    logic [10:0] tick_reg;
    logic [8:0] uf_reg;
    wire logic tick_end = (tick_reg == TICK_LAST);
    wire logic [8:0] period_last = 9'((`UFRAMES_PER_MS << poll_exp) - 1); // see R11 see R13
    wire logic period_end = tick_end && (uf_reg == period_last);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_reg <= 11'h000;
            uf_reg <= 9'h000;
            due <= 1'b0;
        end else if (ce) begin
            due <= !restart && period_end;
            if (restart || tick_end) begin
                tick_reg <= 11'h000;
            end else begin
                tick_reg <= tick_reg + 11'h001;
            end
            if (restart || period_end) begin
                uf_reg <= 9'h000;
            end else if (tick_end) begin
                uf_reg <= uf_reg + 9'h001;
            end
        end
    end

endmodule
`default_nettype wire

/* hdl/split_intr_exec.sv */
// What this block does
// R1: Bit 46 chooses split or high-speed transaction.
// R2: Kind 11 is interrupt; token 00 OUT, 01 IN.
// R3: Function address from bits 41 down to 35.
// R4: Endpoint number from bits 34:32 plus bit 31.
// R5: Bits 28:18 give largest single packet size.
// R6: Software keeps packet size at most 64 bytes.
// R7: Bits 17:3 give total descriptor byte count.
// R8: Software keeps total byte count within 4 kB.
// R9: Valid clears at completion or fatal error.
// R10: Software sets valid when ready; set means active.
// R11: Polling period is power-of-two microframe count.
// R12: Active flag mirrors valid; hardware clears it. Here software writes it separately at OFS_ACTIVE.
// R13: Code 00001 means 2 ms, doubling to 32 ms.
// R14: Reserved bits ignored; invalid descriptors never issue.
//
// Runs one interrupt descriptor held in registers behind an AHB-Lite slave.
// Assumes a single bus master, hclk at 10 MHz and a transaction engine outside
// that answers each request with one txn_done pulse.
`timescale 1ns/1ns
`default_nettype none
`include "split_intr_cfg.svh"

module split_intr_exec
    import split_intr_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic txn_req,
    output logic txn_split,
    output logic txn_in,
    output logic [6:0] txn_function_addr,
    output logic [3:0] txn_endpoint_number,
    output logic [10:0] txn_len,
    input wire logic txn_done,
    input wire logic txn_fatal,
    output logic desc_retired
);

    // ==========================================
    // Registers
    word_t desc_lo_reg;
    word_t desc_hi_reg;
    logic [7:0] poll_reg;
    logic active_reg;
    byte_count_t remaining_reg;
    exec_state_t state_reg;
    logic [15:0] txn_count_reg;
    logic fatal_seen_reg;
    logic wr_pend_reg;
    logic rd_pend_reg;
    logic [7:0] addr_reg;

    // ==========================================
    // Descriptor decode
    logic split_sel;
    logic [1:0] transfer_kind;
    logic token_in;
    logic legal;
    logic [6:0] function_addr;
    logic [3:0] endpoint_number;
    payload_t max_payload_size;
    byte_count_t transfer_byte_count;
    logic desc_valid;
    logic [2:0] poll_exp;
    logic poll_due;

    descriptor_fields u_fields (
        .desc_lo(desc_lo_reg),
        .desc_hi(desc_hi_reg),
        .uframe(poll_reg),
        .split_sel(split_sel),
        .transfer_kind(transfer_kind),
        .token_in(token_in),
        .legal(legal),
        .function_addr(function_addr),
        .endpoint_number(endpoint_number),
        .max_payload_size(max_payload_size),
        .transfer_byte_count(transfer_byte_count),
        .desc_valid(desc_valid),
        .poll_exp(poll_exp)
    );

    wire logic timer_restart = (state_reg != ST_WAIT);

    poll_timer u_timer (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .restart(timer_restart),
        .poll_exp(poll_exp),
        .due(poll_due)
    );

    // ==========================================
    // Bus decode
    wire logic bus_take = hsel && hready && htrans[1];
    wire logic wr_take = bus_take && hwrite;
    wire logic rd_take = bus_take && !hwrite;
    wire logic wr_lo = wr_pend_reg && (addr_reg == `OFS_DESC_LO);
    wire logic wr_hi = wr_pend_reg && (addr_reg == `OFS_DESC_HI);
    wire logic wr_poll = wr_pend_reg && (addr_reg == `OFS_POLL);
    wire logic wr_active = wr_pend_reg && (addr_reg == `OFS_ACTIVE);

    wire word_t status_word = {8'h00, txn_count_reg, 2'h0, fatal_seen_reg,
                               state_reg, active_reg, desc_valid};
    wire word_t progress_word = {17'h00000, remaining_reg};
    wire word_t read_word =
        (addr_reg == `OFS_DESC_LO) ? desc_lo_reg :
        (addr_reg == `OFS_DESC_HI) ? desc_hi_reg :
        (addr_reg == `OFS_POLL) ? {24'h000000, poll_reg} :
        (addr_reg == `OFS_ACTIVE) ? {31'h00000000, active_reg} :
        (addr_reg == `OFS_STATUS) ? status_word :
        (addr_reg == `OFS_PROGRESS) ? progress_word :
        `RST_WORD;

    // ==========================================
    // Execution decode
    wire logic [15:0] rem_wide = {1'b0, remaining_reg};
    wire logic [15:0] mps_wide = {5'h00, max_payload_size};
    wire logic last_packet = (rem_wide <= mps_wide); // see R5
    wire payload_t next_len = last_packet ? remaining_reg[10:0] : max_payload_size;
    wire logic start_ok = desc_valid && legal && (remaining_reg != 15'h0000);
    wire logic start_bad = desc_valid && !legal;
    wire logic start_empty = desc_valid && legal && (remaining_reg == 15'h0000);
    wire logic finish_ok = (state_reg == ST_BUSY) && txn_done && !txn_fatal && last_packet;
    wire logic finish_bad = (state_reg == ST_BUSY) && txn_done && txn_fatal;
    wire logic idle_end = (state_reg == ST_IDLE) && (start_bad || start_empty);
    wire logic retire = finish_ok || finish_bad || idle_end; // see R9 see R12
    wire byte_count_t rem_after = remaining_reg - {4'h0, txn_len};
    wire logic load_count = wr_lo && hwdata[`VALID_BIT];

    // ==========================================
    // Execution state machine
    exec_state_t state_next;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (start_ok) begin
                    state_next = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!desc_valid) begin
                    state_next = ST_IDLE; // see R14
                end else if (poll_due) begin
                    state_next = ST_BUSY; // see R11
                end
            end
            ST_BUSY: begin
                if (txn_done) begin
                    state_next = (finish_ok || finish_bad) ? ST_IDLE : ST_WAIT;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // ==========================================
    // Bus slave
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg <= 8'h00;
            hrdata <= `RST_WORD;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (ce) begin
            wr_pend_reg <= wr_take;
            rd_pend_reg <= rd_take;
            if (bus_take) begin
                addr_reg <= haddr[7:0];
            end
            hreadyout <= !rd_take;
            if (rd_pend_reg) begin
                hrdata <= read_word;
            end
        end
    end

    // ==========================================
    // Descriptor registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            desc_lo_reg <= `RST_WORD;
            desc_hi_reg <= `RST_WORD;
            poll_reg <= 8'h00;
            active_reg <= 1'b0;
            remaining_reg <= 15'h0000;
            fatal_seen_reg <= 1'b0;
        end else if (ce) begin
            if (wr_lo) begin
                desc_lo_reg <= hwdata; // see R10
            end else if (retire) begin
                desc_lo_reg[`VALID_BIT] <= 1'b0; // see R9
            end
            if (wr_hi) begin
                desc_hi_reg <= hwdata;
            end
            if (wr_poll) begin
                poll_reg <= hwdata[7:0];
            end
            if (wr_active) begin
                active_reg <= hwdata[0];
            end else if (retire) begin
                active_reg <= 1'b0; // see R12
            end
            if (load_count) begin
                remaining_reg <= hwdata[`BCNT_HI:`BCNT_LO]; // see R7
            end else if ((state_reg == ST_BUSY) && txn_done && !txn_fatal) begin
                remaining_reg <= rem_after;
            end
            if (finish_bad || (idle_end && start_bad)) begin
                fatal_seen_reg <= 1'b1; // see R9
            end else if (load_count) begin
                fatal_seen_reg <= 1'b0;
            end
        end
    end

    // ==========================================
    // Transaction requests
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= ST_IDLE;
            txn_req <= 1'b0;
            txn_split <= 1'b0;
            txn_in <= 1'b0;
            txn_function_addr <= 7'h00;
            txn_endpoint_number <= 4'h0;
            txn_len <= 11'h000;
            txn_count_reg <= 16'h0000;
            desc_retired <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
            desc_retired <= retire;
            if ((state_reg == ST_WAIT) && desc_valid && poll_due) begin
                txn_req <= 1'b1; // see R14
                txn_split <= split_sel; // see R1
                txn_in <= token_in; // see R2
                txn_function_addr <= function_addr; // see R3
                txn_endpoint_number <= endpoint_number; // see R4
                txn_len <= next_len; // see R5
                txn_count_reg <= txn_count_reg + 16'h0001;
            end else if ((state_reg == ST_BUSY) && txn_done) begin
                txn_req <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

/* testbench/txn_partner.sv */
// Transaction engine model: answers each request with one done pulse.
// Assumes txn_req stays high until the edge after done is sampled.
`timescale 1ns/1ns
`default_nettype none
module txn_partner (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic txn_req,
    input wire logic [7:0] delay,
    input wire logic fatal_en,
    output logic txn_done,
    output logic txn_fatal
);
    // ==========
    // Answer
    logic busy;
    logic [7:0] cnt;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy <= 1'b0;
            cnt <= 8'h0;
            txn_done <= 1'b0;
            txn_fatal <= 1'b0;
        end else begin
            txn_done <= 1'b0;
            txn_fatal <= 1'b0;
            if (txn_req && !busy && !txn_done) begin
                busy <= 1'b1;
                cnt <= delay;
            end else if (busy && cnt == 8'h0) begin
                busy <= 1'b0;
                txn_done <= 1'b1;
                txn_fatal <= fatal_en;
            end else if (busy) begin
                cnt <= cnt - 8'h1;
            end
        end
    end
endmodule
`default_nettype wire

/* testbench/split_intr_exec_properties.sv */
// Concurrent checks on the ports of split_intr_exec.
// Assumes one clock domain; bound to the design below.
`timescale 1ns/1ns
`default_nettype none
`include "split_intr_cfg.svh"
module split_intr_exec_properties (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic txn_req,
    input wire logic txn_split,
    input wire logic txn_in,
    input wire logic [6:0] txn_function_addr,
    input wire logic [3:0] txn_endpoint_number,
    input wire logic [10:0] txn_len,
    input wire logic txn_done,
    input wire logic txn_fatal,
    input wire logic desc_retired
);
    // ==========
    // Helpers
    localparam int GAP_MIN = 8 * `UFRAME_CYCLES - 2;
    logic taken;
    logic [15:0] gap;
    assign taken = hsel && hready && htrans[1] && ce;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gap <= 16'hffff;
        end else if (txn_req && txn_done) begin
            gap <= 16'h0;
        end else if (ce && gap != 16'hffff) begin
            gap <= gap + 16'h1;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_read_answer;
        !hreadyout ##1 hreadyout;
    endsequence
    // ==========
    // Assertions
    a_read_wait: assert property (taken && !hwrite |=> s_read_answer)
        else $error("read answer is not one wait cycle");
    a_write_nowait: assert property (taken && hwrite |=> hreadyout)
        else $error("write stalled");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    a_fields_stable: assert property (txn_req && $past(txn_req) |->
        $stable({txn_split, txn_in, txn_function_addr, txn_endpoint_number, txn_len}))
        else $error("request fields moved");
    a_req_release: assert property (txn_req && txn_done |=> !txn_req)
        else $error("request held after done");
    a_fatal_retire: assert property (txn_req && txn_done && txn_fatal |=> desc_retired)
        else $error("fatal did not retire");
    a_retire_pulse: assert property (desc_retired |=> !desc_retired)
        else $error("retire longer than a cycle");
    a_poll_gap: assert property ($rose(txn_req) |-> gap >= GAP_MIN)
        else $error("poll came too soon");
endmodule
bind split_intr_exec split_intr_exec_properties i_props (.hclk, .hresetn, .ce, .hsel,
    .htrans, .hwrite, .hready, .hreadyout, .hresp, .txn_req, .txn_split, .txn_in,
    .txn_function_addr, .txn_endpoint_number, .txn_len, .txn_done, .txn_fatal, .desc_retired);
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for split_intr_exec and its partner model.
// Assumes the package, design, partner and checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "split_intr_cfg.svh"
module testbench import split_intr_pkg::*;;
    localparam int P = 8 * `UFRAME_CYCLES;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, p_fatal = 1'b0, ce = 1'b1;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [7:0] p_delay = 8'h3;
    word_t haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic hreadyout, hresp, txn_req, txn_split, txn_in, txn_done, txn_fatal, desc_retired;
    logic [6:0] txn_function_addr;
    logic [3:0] txn_endpoint_number;
    logic [10:0] txn_len;
    int mismatches = 0, samples_checked = 0, cycles = 0, retired = 0;
    split_intr_exec i_split_intr_exec (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .txn_req,
        .txn_split, .txn_in, .txn_function_addr, .txn_endpoint_number, .txn_len, .txn_done,
        .txn_fatal, .desc_retired);
    txn_partner i_txn_partner (.hclk, .hresetn, .txn_req, .delay(p_delay),
        .fatal_en(p_fatal), .txn_done, .txn_fatal);
    always #50 hclk = ~hclk;
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (desc_retired === 1'b1) retired <= retired + 1;
        if (cycles == 80000) begin
            mismatches = mismatches + 1;
            finish_test();
        end
    end
    // ==========
    // Shared tasks
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check(input string n, input word_t e, input word_t g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic wr, input word_t wd, output word_t rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rd_check(input logic [7:0] a, input word_t m, input word_t e, input string n);
        word_t d;
        bus(a, 1'b0, 32'h0, d);
        check(n, e, d & m);
    endtask
    task automatic load(input word_t hi, input logic [7:0] poll, input word_t lo);
        word_t d;
        bus(`OFS_DESC_HI, 1'b1, hi, d);
        bus(`OFS_POLL, 1'b1, {24'h0, poll}, d);
        bus(`OFS_ACTIVE, 1'b1, {31'h0, lo[0]}, d);
        bus(`OFS_DESC_LO, 1'b1, lo, d);
    endtask
    task automatic expect_txn(input logic [23:0] f, input int per);
        int n;
        n = 0;
        while (txn_req !== 1'b1 && n <= per + 6) begin
            @(posedge hclk);
            n++;
        end
        check("poll delay", 32'h1, {31'h0, n >= per - 4 && n <= per + 6});
        check("fields", {8'h0, f}, {8'h0, txn_split, txn_in, txn_function_addr,
            txn_endpoint_number, txn_len});
        n = 0;
        while (txn_req === 1'b1 && n < 60) begin
            @(posedge hclk);
            n++;
        end
    endtask
    // ==========
    // Scenarios
    task automatic t_idle_regs();
        int n;
        int r;
        word_t d;
        r = retired;
        rd_check(`OFS_STATUS, 32'h3f, 32'h04, "reset status");
        rd_check(8'h20, 32'hffffffff, 32'h0, "unmapped");
        bus(`OFS_PROGRESS, 1'b1, 32'h5, d);
        rd_check(`OFS_PROGRESS, 32'hffffffff, 32'h0, "read only");
        load({17'h0, 1'b1, 2'h3, 2'h1, 7'h11, 3'h1}, 8'h00, 32'h0020_0080);
        bus(`OFS_ACTIVE, 1'b1, 32'h1, d);
        bus(`OFS_DESC_LO, 1'b1, 32'h0020_0081, d);
        bus(`OFS_DESC_LO, 1'b1, 32'h0020_0080, d);
        bus(`OFS_ACTIVE, 1'b1, 32'h0, d);
        n = 0;
        repeat (P + 100) begin
            @(posedge hclk);
            if (txn_req !== 1'b0) n++;
        end
        check("skipped", 32'h0, 32'(n));
        check("not retired", 32'(r), 32'(retired));
    endtask
    task automatic t_out_split();
        int r;
        r = retired;
        load({17'h1ffff, 1'b1, 2'h3, 2'h0, 7'h5a, 3'h4}, 8'h07,
            {1'b1, 2'h3, 11'h040, 15'h064, 2'h3, 1'b1});
        rd_check(`OFS_ACTIVE, 32'h1, 32'h1, "active set");
        ce <= 1'b0;
        repeat (20) @(posedge hclk);
        ce <= 1'b1;
        expect_txn({2'h2, 7'h5a, 4'h9, 11'h040}, P);
        rd_check(`OFS_PROGRESS, 32'h7fff, 32'h24, "remaining");
        expect_txn({2'h2, 7'h5a, 4'h9, 11'h024}, P);
        rd_check(`OFS_STATUS, 32'h3, 32'h0, "valid active");
        check("retired", 32'(r + 1), 32'(retired));
    endtask
    task automatic t_in_fatal();
        int r;
        r = retired;
        p_fatal <= 1'b1;
        p_delay <= 8'h0;
        load({17'h0, 1'b0, 2'h3, 2'h1, 7'h21, 3'h3}, 8'h08,
            {1'b0, 2'h0, 11'h008, 15'h028, 2'h0, 1'b1});
        expect_txn({2'h1, 7'h21, 4'h6, 11'h008}, 2 * P);
        p_fatal <= 1'b0;
        rd_check(`OFS_STATUS, 32'h23, 32'h20, "fatal retire");
        rd_check(`OFS_PROGRESS, 32'h7fff, 32'h28, "remaining kept");
        check("retired", 32'(r + 1), 32'(retired));
    endtask
    task automatic t_bad_codes();
        for (int i = 0; i < 4; i++) begin
            int r;
            r = retired;
            load({17'h0, 1'b1, (i == 3) ? 2'h3 : 2'(i), (i == 3) ? 2'h2 : 2'h0, 7'h11, 3'h1},
                8'h00, 32'h0020_0041);
            rd_check(`OFS_STATUS, 32'h3, 32'h0, "refused");
            check("retired", 32'(r + 1), 32'(retired));
        end
    endtask
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_idle_regs();
        t_out_split();
        t_in_fatal();
        t_bad_codes();
        finish_test();
    end
endmodule
`default_nettype wire
